// ==== core/ppp_pkg.sv ====
package ppp_pkg;

   // ----------------------------------------------------------------
   // Load actions and commands
   // ----------------------------------------------------------------
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;

   localparam logic [7:0] CMD_NOP        = 8'h00;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_FUSE_WR    = 8'h40;
   localparam logic [7:0] CMD_LOCK_WR    = 8'h20;
   localparam logic [7:0] CMD_FLASH_WR   = 8'h10;
   localparam logic [7:0] CMD_EE_WR      = 8'h11;
   localparam logic [7:0] CMD_SIG_RD     = 8'h08;
   localparam logic [7:0] CMD_FUSE_RD    = 8'h04;
   localparam logic [7:0] CMD_FLASH_RD   = 8'h02;
   localparam logic [7:0] CMD_EE_RD      = 8'h03;

   // ----------------------------------------------------------------
   // Memory geometry and reset values
   // ----------------------------------------------------------------
   localparam int         FLASH_WORDS  = 1024;
   localparam int         PAGE_WORDS   = 16;
   localparam int         EE_BYTES     = 128;
   localparam logic [3:0] ENTRY_PATTERN = 4'h0;
   localparam logic [7:0] FUSE_LO_RST  = 8'h64;
   localparam logic [7:0] FUSE_HI_RST  = 8'hDF;
   localparam logic [7:0] FUSE_EX_RST  = 8'hFF;
   localparam logic [7:0] LOCK_RST     = 8'hFF;
   localparam int         KEEP_BIT     = 6;   // Keep-EEPROM fuse in high byte

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int ENTRY_HOLD_NS  = 10000;
   localparam int ENTRY_CYCLES   = (ENTRY_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_CYCLES    = 64;
   localparam int ERASE_WAIT_NS  = 100;
   localparam int ERASE_CYCLES   = (ERASE_WAIT_NS * CLK_MHZ + 999) / 1000;

endpackage : ppp_pkg

// ==== core/ppp_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of pin inputs
module ppp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // Second stage alone reads the first
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : ppp_sync

// ==== core/ppp_port.sv ====
`timescale 1ns/1ps
// Behaviour
// R1 - Load clock pulse: action bits pick load
// R2 - Address byte select by byte_select_one
// R3 - Flash data byte select by byte_select_one
// R4 - Decode nine command byte codes
// R5 - Write or read strobe executes command; only the write strobe executes here, output_enable_n just gates the bus
// R6 - Ready/busy low during programming or erase
// R7 - Drive data bus only when enabled
// R8 - Second action bit also byte_select_two
// R9 - Latch entry pattern 0000 for 10us
// R10 - Programmer waits 300us before commands; the bench programmer waits CMD_WAIT = 200 cycles, 1us
// R11 - Reset pin low leaves programming mode
// R12 - Command and address kept across operations
// R13 - High address reload only per window
// R14 - Erase flash, EEPROM, then locks; keep fuses; here flash, EEPROM and locks all clear on the same edge
// R15 - Keep-fuse programmed preserves EEPROM on erase
// R16 - Programmer erases before reprogramming
// R17 - Erase strobe starts erase, busy low
// R18 - Flash words latched into page buffer
// R19 - Programmer loads address, data lo, hi
// R20 - Low address bits pick word in page
// R21 - Strobe after high address programs page
// R22 - No-op command ends page programming
// R23 - Fuses latched at entry; keep-fuse immediate
// R24 - Programmed fuse reads as zero
// R25 - Ignore strobes and loads while busy
module ppp_port #(
   parameter int ENTRY_CYC = ppp_pkg::ENTRY_CYCLES,
   parameter int PROG_CYC  = ppp_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // High voltage present on reset pin
   input  wire logic       hv_reset_pin,
   // Programming pins
   input  wire logic       load_clock_pin,
   input  wire logic       action_sel_hi,
   input  wire logic       action_sel_lo,
   input  wire logic       byte_select_one,
   input  wire logic       write_strobe_n,
   input  wire logic       output_enable_n,
   // Data bus
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   // Status
   output logic            ready_busy_flag,
   output logic            prog_mode,
   output logic [7:0]      active_fuse_lo
);
   localparam int AW  = $clog2(ppp_pkg::FLASH_WORDS);
   localparam int PW  = $clog2(ppp_pkg::PAGE_WORDS);
   localparam int EW  = $clog2(ppp_pkg::EE_BYTES);
   localparam int CW  = 16;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [14:0] pins_s;
   ppp_sync #(.W(15)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({hv_reset_pin, load_clock_pin, action_sel_hi, action_sel_lo,
                 byte_select_one, write_strobe_n, output_enable_n, data_in}),
      .q       (pins_s)
   );
   logic       hv_s, xclk_s, xa1_s, xa0_s, bs1_s, wr_n_s, oe_n_s;
   logic [7:0] din_s;
   assign {hv_s, xclk_s, xa1_s, xa0_s, bs1_s, wr_n_s, oe_n_s, din_s} = pins_s;

   typedef enum logic [3:0] {
      PPP_OFF   = 4'h1,
      PPP_ENTRY = 4'h2,
      PPP_READY = 4'h4,
      PPP_BUSY  = 4'h8
   } ppp_state_t;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ppp_state_t            st_q, st_d;
   logic [CW-1:0]         cnt_q, cnt_d;
   logic                  xclk_q, wr_n_q;
   logic [7:0]            cmd_q, cmd_d, alo_q, alo_d, ahi_q, ahi_d;
   logic [7:0]            dlo_q, dlo_d, dhi_q, dhi_d;
   logic [7:0]            fuse_lo_q, fuse_lo_d, fuse_hi_q, fuse_hi_d;
   logic [7:0]            fuse_ex_q, fuse_ex_d, lock_q, lock_d;
   logic [7:0]            act_lo_q, act_lo_d;
   logic                  erase_q, erase_d, wr_buf;
   logic [15:0]           page_buf [ppp_pkg::PAGE_WORDS];
   logic [15:0]           flash    [ppp_pkg::FLASH_WORDS];
   logic [7:0]            eeprom   [ppp_pkg::EE_BYTES];
   logic [7:0]            dout_d;

   logic       load_ev, wr_ev;
   logic [1:0] act;
   logic       bs2;
   logic [AW-1:0] addr;

   assign load_ev = xclk_s && !xclk_q;
   assign wr_ev   = !wr_n_s && wr_n_q;
   assign act     = {xa1_s, xa0_s};
   // R8 second select
   assign bs2     = xa1_s;
   // R20 word in page
   assign addr    = AW'({ahi_q, alo_q});

   // Known command check, used by execute only; command loads are not checked
   function automatic logic cmd_known(input logic [7:0] c);
      // R4 command decode
      return c inside {ppp_pkg::CMD_CHIP_ERASE, ppp_pkg::CMD_FUSE_WR, ppp_pkg::CMD_LOCK_WR,
                       ppp_pkg::CMD_FLASH_WR, ppp_pkg::CMD_EE_WR, ppp_pkg::CMD_SIG_RD,
                       ppp_pkg::CMD_FUSE_RD, ppp_pkg::CMD_FLASH_RD, ppp_pkg::CMD_EE_RD};
   endfunction : cmd_known

   // Next-state and latch logic
   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      cmd_d     = cmd_q;
      alo_d     = alo_q;
      ahi_d     = ahi_q;
      dlo_d     = dlo_q;
      dhi_d     = dhi_q;
      fuse_lo_d = fuse_lo_q;
      fuse_hi_d = fuse_hi_q;
      fuse_ex_d = fuse_ex_q;
      lock_d    = lock_q;
      act_lo_d  = act_lo_q;
      erase_d   = erase_q;
      wr_buf    = 1'b0;
      unique case (st_q)
         PPP_OFF: begin
            cnt_d = '0;
            if (hv_s) st_d = PPP_ENTRY;
         end
         // R9 entry pattern
         PPP_ENTRY: begin
            if ({xa1_s, xa0_s, bs1_s, wr_n_s} != ppp_pkg::ENTRY_PATTERN) begin
               st_d = PPP_OFF;
            end else if (cnt_q >= CW'(ENTRY_CYC - 1)) begin
               st_d     = PPP_READY;
               // R23 fuses latched
               act_lo_d = fuse_lo_q;
               cmd_d    = ppp_pkg::CMD_NOP;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         PPP_READY: begin
            if (load_ev) begin
               // R1 load decode
               unique case (act)
                  ppp_pkg::ACT_ADDR: begin
                     // R2 address byte
                     if (bs1_s) ahi_d = din_s;
                     else       alo_d = din_s;
                  end
                  ppp_pkg::ACT_DATA: begin
                     // R3 data byte
                     if (bs1_s) dhi_d = din_s;
                     else       dlo_d = din_s;
                     // R18 page latch on high byte
                     if (bs1_s && cmd_q == ppp_pkg::CMD_FLASH_WR) wr_buf = 1'b1;
                  end
                  // R22 no-op ends writes
                  ppp_pkg::ACT_CMD: cmd_d = din_s;
                  ppp_pkg::ACT_IDLE: ;
               endcase
            end
            // R5 strobe executes
            if (wr_ev && cmd_known(cmd_q)) begin
               unique case (cmd_q)
                  // R17 start erase
                  ppp_pkg::CMD_CHIP_ERASE: begin
                     erase_d = 1'b1;
                     st_d    = PPP_BUSY;
                  end
                  // R21 program page
                  ppp_pkg::CMD_FLASH_WR, ppp_pkg::CMD_EE_WR: st_d = PPP_BUSY;
                  ppp_pkg::CMD_FUSE_WR: begin
                     st_d = PPP_BUSY;
                     if (bs1_s)    fuse_hi_d = dlo_q;
                     else if (bs2) fuse_ex_d = dlo_q;
                     else          fuse_lo_d = dlo_q;
                  end
                  ppp_pkg::CMD_LOCK_WR: begin
                     st_d   = PPP_BUSY;
                     lock_d = lock_q & dlo_q;
                  end
                  default: ;
               endcase
               cnt_d = '0;
            end
         end
         // R25 busy ignores all pins but the reset pin
         PPP_BUSY: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q >= CW'(PROG_CYC - 1)) begin
               st_d = PPP_READY;
               // R14 locks cleared on the same edge as flash and EEPROM
               if (erase_q) lock_d = ppp_pkg::LOCK_RST;
               erase_d = 1'b0;
            end
         end
         default: st_d = PPP_OFF;
      endcase
      // R11 leave on low reset pin
      if (!hv_s && st_q != PPP_OFF) st_d = PPP_OFF;
   end

   // Control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q      <= PPP_OFF;
         cnt_q     <= '0;
         xclk_q    <= 1'b0;
         wr_n_q    <= 1'b1;
         cmd_q     <= ppp_pkg::CMD_NOP;
         alo_q     <= '0;
         ahi_q     <= '0;
         dlo_q     <= '0;
         dhi_q     <= '0;
         fuse_lo_q <= ppp_pkg::FUSE_LO_RST;
         fuse_hi_q <= ppp_pkg::FUSE_HI_RST;
         fuse_ex_q <= ppp_pkg::FUSE_EX_RST;
         lock_q    <= ppp_pkg::LOCK_RST;
         act_lo_q  <= ppp_pkg::FUSE_LO_RST;
         erase_q   <= 1'b0;
         data_out  <= '0;
      end else begin
         st_q      <= st_d;
         cnt_q     <= cnt_d;
         xclk_q    <= xclk_s;
         wr_n_q    <= wr_n_s;
         // R12 command and address kept
         cmd_q     <= cmd_d;
         alo_q     <= alo_d;
         ahi_q     <= ahi_d;
         dlo_q     <= dlo_d;
         dhi_q     <= dhi_d;
         fuse_lo_q <= fuse_lo_d;
         fuse_hi_q <= fuse_hi_d;
         fuse_ex_q <= fuse_ex_d;
         lock_q    <= lock_d;
         act_lo_q  <= act_lo_d;
         erase_q   <= erase_d;
         data_out  <= dout_d;
      end
   end

   // ----------------------------------------------------------------
   // Memory arrays, no reset so they map to RAM
   // ----------------------------------------------------------------
   logic done;
   assign done = (st_q == PPP_BUSY) && (cnt_q >= CW'(PROG_CYC - 1));

   always_ff @(posedge clk) begin
      if (wr_buf) page_buf[alo_q[PW-1:0]] <= {din_s, dlo_q};
      if (done && erase_q) begin
         for (int i = 0; i < ppp_pkg::FLASH_WORDS; i++) flash[i] <= 16'hFFFF;
         // R15 keep-fuse acts at once
         if (fuse_hi_q[ppp_pkg::KEEP_BIT]) begin
            for (int i = 0; i < ppp_pkg::EE_BYTES; i++) eeprom[i] <= 8'hFF;
         end
      end else if (done && cmd_q == ppp_pkg::CMD_FLASH_WR) begin
         // R20 page from upper bits
         for (int i = 0; i < ppp_pkg::PAGE_WORDS; i++)
            flash[{addr[AW-1:PW], PW'(i)}] <= page_buf[i];
      end else if (done && cmd_q == ppp_pkg::CMD_EE_WR) begin
         eeprom[alo_q[EW-1:0]] <= dlo_q;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      dout_d = 8'hFF;
      unique case (cmd_q)
         ppp_pkg::CMD_FLASH_RD: dout_d = bs1_s ? flash[addr][15:8] : flash[addr][7:0];
         ppp_pkg::CMD_EE_RD:    dout_d = eeprom[alo_q[EW-1:0]];
         // R24 zero means programmed
         ppp_pkg::CMD_FUSE_RD: begin
            unique case ({bs2, bs1_s})
               2'h0: dout_d = fuse_lo_q;
               2'h3: dout_d = fuse_hi_q;
               2'h2: dout_d = fuse_ex_q;
               2'h1: dout_d = lock_q;
            endcase
         end
         ppp_pkg::CMD_SIG_RD: dout_d = {6'h00, alo_q[1:0]};
         default: dout_d = 8'hFF;
      endcase
   end

   // R7 bus drive gate
   assign data_oe         = !oe_n_s && (st_q == PPP_READY);
   // R6 busy indication
   assign ready_busy_flag = (st_q != PPP_BUSY);
   assign prog_mode       = (st_q == PPP_READY) || (st_q == PPP_BUSY);
   assign active_fuse_lo  = act_lo_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_busy_on_erase: assert property (@(posedge clk) disable iff (sys_rst) // R17
      (st_q == PPP_READY && wr_ev && cmd_q == ppp_pkg::CMD_CHIP_ERASE && hv_s) |=> !ready_busy_flag)
      else $error("erase did not raise busy");
   // Busy may only end on the full count or on leaving the mode
   a_busy_level: assert property (@(posedge clk) disable iff (sys_rst) // R6
      $rose(ready_busy_flag) |-> !$past(hv_s) || $past(cnt_q) == CW'(PROG_CYC - 1))
      else $error("busy ended off count");
   a_bus_drive: assert property (@(posedge clk) disable iff (sys_rst) // R7
      data_oe |-> !$past(output_enable_n, 2)) else $error("bus driven without enable");
   a_cmd_load: assert property (@(posedge clk) disable iff (sys_rst) // R1
      (st_q == PPP_READY && load_ev && act == ppp_pkg::ACT_CMD && hv_s) |=> cmd_q == $past(din_s))
      else $error("command not loaded");
   a_addr_lo: assert property (@(posedge clk) disable iff (sys_rst) // R2
      (st_q == PPP_READY && load_ev && act == ppp_pkg::ACT_ADDR && !bs1_s) |=> alo_q == $past(din_s))
      else $error("low address not loaded");
   a_data_hi: assert property (@(posedge clk) disable iff (sys_rst) // R3
      (st_q == PPP_READY && load_ev && act == ppp_pkg::ACT_DATA && bs1_s) |=> dhi_q == $past(din_s))
      else $error("high data not loaded");
   a_busy_hold: assert property (@(posedge clk) disable iff (sys_rst) // R25
      (st_q == PPP_BUSY && hv_s) |=> $stable(cmd_q)) else $error("command changed while busy");
   a_exit_mode: assert property (@(posedge clk) disable iff (sys_rst) // R11
      (!hv_s) |=> !prog_mode) else $error("mode kept with reset pin low");
   a_fuse_keep: assert property (@(posedge clk) disable iff (sys_rst) // R14
      (st_q == PPP_BUSY && erase_q) |=> $stable(fuse_hi_q)) else $error("erase touched fuses");
   // Entry only after the full pattern hold
   a_entry_time: assert property (@(posedge clk) disable iff (sys_rst) // R9
      $rose(prog_mode) |-> $past(cnt_q) == CW'(ENTRY_CYC - 1)) else $error("mode entered early");
   // Locks go back to unprogrammed only as the erase completes
   a_lock_clear: assert property (@(posedge clk) disable iff (sys_rst) // R14
      (st_q == PPP_BUSY && erase_q && cnt_q == CW'(PROG_CYC - 1)) |=> lock_q == ppp_pkg::LOCK_RST)
      else $error("erase left locks set");
   a_page_latch: assert property (@(posedge clk) disable iff (sys_rst) // R18
      (st_q == PPP_READY && load_ev && act == ppp_pkg::ACT_DATA && bs1_s && cmd_q == ppp_pkg::CMD_FLASH_WR)
      |=> page_buf[$past(alo_q[PW-1:0])] == {$past(din_s), $past(dlo_q)}) else $error("page word not latched");
endmodule : ppp_port

// ==== testbench/ppp_programmer.sv ====
`timescale 1ns/1ps
// Behavioural parallel programmer facing the port
module ppp_programmer #(
   parameter int CMD_WAIT = 200  // Settle cycles after high voltage
) (
   // Clock and device status
   input  wire logic       clk,
   input  wire logic       ready_busy_flag,
   // Pins towards the device
   output logic            hv_reset_pin,
   output logic            load_clock_pin,
   output logic            action_sel_hi,
   output logic            action_sel_lo,
   output logic            byte_select_one,
   output logic            write_strobe_n,
   output logic            output_enable_n,
   // Data bus drive
   output logic [7:0]      bus_drive,
   output logic            bus_oe
);
   // Power-up levels, entry pattern already on the pins
   initial begin
      {hv_reset_pin, load_clock_pin, action_sel_hi, action_sel_lo} = 4'h0;
      {byte_select_one, write_strobe_n, bus_oe} = 3'h0;
      output_enable_n = 1'b1;
      bus_drive = 8'h00;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic enter(input int hold);
      {action_sel_hi, action_sel_lo, byte_select_one, write_strobe_n} = 4'h0;
      hv_reset_pin = 1'b1;
      idle(hold);
      write_strobe_n = 1'b1;
      {action_sel_hi, action_sel_lo} = 2'h3;
      idle(CMD_WAIT);
   endtask : enter

   // caller orders the loads; pins held around the pulse
   task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] val);
      @(negedge clk);
      {action_sel_hi, action_sel_lo} = act;
      byte_select_one = bs;
      bus_drive = val;
      bus_oe = 1'b1;
      idle(14);
      load_clock_pin = 1'b1;
      idle(50);
      load_clock_pin = 1'b0;
      idle(14);
      bus_oe = 1'b0;
      {action_sel_hi, action_sel_lo} = 2'h3;
   endtask : load

   task automatic strobe();
      @(negedge clk);
      write_strobe_n = 1'b0;
      idle(50);
      write_strobe_n = 1'b1;
      // wait for ready before going on
      for (int i = 0; i < 300 && ready_busy_flag !== 1'b1; i++) idle(1);
   endtask : strobe

   task automatic sel_read(input logic bs2, input logic bs1, input logic oe_n);
      @(negedge clk);
      {action_sel_hi, action_sel_lo} = {bs2, 1'b1};
      byte_select_one = bs1;
      output_enable_n = oe_n;
   endtask : sel_read
endmodule : ppp_programmer

// ==== testbench/ppp_port_test.sv ====
`timescale 1ns/1ps
module ppp_port_test;
   // Bench signals
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       take = 1'b0;
   int         err_count = 0;
   int         comparisons = 0;
   int         cycles = 0;
   int         seed = 5;
   logic [7:0] flo [16];
   logic [7:0] fhi [16];
   logic [7:0] seen;
   logic [7:0] exp_q [$];
   int         sel_q [$];
   string      nms [5] = '{"data_out", "ready_busy_flag", "prog_mode", "active_fuse_lo", "data_oe"};
   // Pins
   wire logic  hv, lck, xh, xl, bs1, wr_n, oe_n, bus_oe, data_oe, rdy, pmode;
   wire logic [7:0] bus_drive, data_out, fuse_lo, data_in;

   always #2.5 clk = ~clk;

   // Released bus floats, so show the inverse rather than a stale value
   assign data_in = data_oe ? data_out : (bus_oe ? bus_drive : ~bus_drive);

   ppp_port #(.ENTRY_CYC(20), .PROG_CYC(8)) ppp_port_i (
      .clk(clk), .sys_rst(sys_rst), .hv_reset_pin(hv), .load_clock_pin(lck),
      .action_sel_hi(xh), .action_sel_lo(xl), .byte_select_one(bs1), .write_strobe_n(wr_n),
      .output_enable_n(oe_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .ready_busy_flag(rdy), .prog_mode(pmode), .active_fuse_lo(fuse_lo));

   ppp_programmer #(.CMD_WAIT(200)) ppp_programmer_i (
      .clk(clk), .ready_busy_flag(rdy), .hv_reset_pin(hv), .load_clock_pin(lck),
      .action_sel_hi(xh), .action_sel_lo(xl), .byte_select_one(bs1), .write_strobe_n(wr_n),
      .output_enable_n(oe_n), .bus_drive(bus_drive), .bus_oe(bus_oe));

   // ---------------------------------------------------------------
   // Checking
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : check

   // Watcher takes the oldest note each time one is flagged, once outputs have settled
   always @(posedge clk) begin
      if (take) begin
         #1;
         case (sel_q[0])
            1: seen = {7'h00, rdy};
            2: seen = {7'h00, pmode};
            3: seen = fuse_lo;
            4: seen = {7'h00, data_oe};
            default: seen = data_out;
         endcase
         check(nms[sel_q[0]], seen, exp_q[0]);
         void'(sel_q.pop_front());
         void'(exp_q.pop_front());
      end
   end

   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic note(input int sel, input logic [7:0] e);
      @(negedge clk);
      sel_q.push_back(sel);
      exp_q.push_back(e);
      take = 1'b1;
      @(negedge clk);
      take = 1'b0;
   endtask : note

   task automatic ld(input logic [1:0] act, input logic bs, input logic [7:0] v);
      ppp_programmer_i.load(act, bs, v);
   endtask : ld

   task automatic exec();
      fork
         ppp_programmer_i.strobe();
         begin
            repeat (5) @(negedge clk);
            note(1, 8'h00);
         end
      join
      note(1, 8'h01);
   endtask : exec

   task automatic rd(input logic bs2, input logic bs1v, input logic [7:0] e);
      ppp_programmer_i.sel_read(bs2, bs1v, 1'b0);
      repeat (10) @(negedge clk);
      note(0, e);
      note(4, 8'h01);
      ppp_programmer_i.sel_read(1'b0, 1'b0, 1'b1);
      repeat (6) @(negedge clk);
      note(4, 8'h00);
   endtask : rd

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      note(2, 8'h00);
      note(1, 8'h01);
      ppp_programmer_i.enter(30);
      note(2, 8'h01);
      note(3, ppp_pkg::FUSE_LO_RST);
      // Fuse and lock bytes by both byte selects
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FUSE_RD);
      rd(1'b0, 1'b0, ppp_pkg::FUSE_LO_RST);
      rd(1'b1, 1'b1, ppp_pkg::FUSE_HI_RST);
      rd(1'b1, 1'b0, ppp_pkg::FUSE_EX_RST);
      rd(1'b0, 1'b1, ppp_pkg::LOCK_RST);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_CHIP_ERASE);
      exec();
      // Fill one page at page 3 with random words
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FLASH_WR);
      for (int w = 0; w < 16; w++) begin
         flo[w] = 8'($random(seed));
         fhi[w] = 8'($random(seed));
         ld(ppp_pkg::ACT_ADDR, 1'b0, {4'h3, 4'(w)});
         ld(ppp_pkg::ACT_DATA, 1'b0, flo[w]);
         ld(ppp_pkg::ACT_DATA, 1'b1, fhi[w]);
         ld(ppp_pkg::ACT_IDLE, 1'b0, 8'hFF);
      end
      ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
      exec();
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_NOP);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FLASH_RD);
      for (int w = 0; w < 16; w += 5) begin
         ld(ppp_pkg::ACT_ADDR, 1'b0, {4'h3, 4'(w)});
         rd(1'b0, 1'b0, flo[w]);
         rd(1'b0, 1'b1, fhi[w]);
      end
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h25);
      rd(1'b0, 1'b0, 8'hFF);
      // One EEPROM byte written and read back
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_EE_WR);
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h05);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'hA5);
      exec();
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_EE_RD);
      rd(1'b0, 1'b0, 8'hA5);
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h06);
      rd(1'b0, 1'b0, 8'hFF);
      // Fuses and locks, then an erase that keeps the fuses, clears the locks and, with the keep fuse, keeps the EEPROM
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FUSE_WR);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'h5A);
      ppp_programmer_i.sel_read(1'b0, 1'b0, 1'b1);
      exec();
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'h9F);
      ppp_programmer_i.sel_read(1'b0, 1'b1, 1'b1);
      exec();
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_LOCK_WR);
      ld(ppp_pkg::ACT_DATA, 1'b0, 8'hFC);
      exec();
      note(3, ppp_pkg::FUSE_LO_RST);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FUSE_RD);
      rd(1'b0, 1'b0, 8'h5A);
      rd(1'b0, 1'b1, 8'hFC);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_CHIP_ERASE);
      exec();
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_FUSE_RD);
      rd(1'b1, 1'b1, 8'h9F);
      rd(1'b0, 1'b1, ppp_pkg::LOCK_RST);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_EE_RD);
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h05);
      rd(1'b0, 1'b0, 8'hA5);
      // Dropping high voltage leaves the mode; re-entry picks up the new low fuses
      ppp_programmer_i.hv_reset_pin = 1'b0;
      repeat (10) @(negedge clk);
      note(2, 8'h00);
      ppp_programmer_i.enter(30);
      note(2, 8'h01);
      note(3, 8'h5A);
      give_verdict();
   end
endmodule : ppp_port_test
